// *** inc/ier_pkg.sv ***
// Package for the interrupt enable and pin routing block.
// Assumes an APB slave with 32-bit data and a single clock pclk.
package ier_pkg;
   // Printed offsets are not multiples of four: they are word indices
   localparam logic [7:0]  IDX_ENABLE   = 8'h2d;
   localparam logic [7:0]  IDX_ROUTING  = 8'h2e;
   localparam logic [7:0]  IDX_PADCFG   = 8'h40;
   localparam logic [7:0]  IDX_STATUS   = 8'h41;
   localparam logic [7:0]  IDX_MASK     = 8'h42;
   localparam logic [7:0]  IDX_SOURCE   = 8'h0c;
   localparam logic [11:0] ADDR_ENABLE  = {2'h0, IDX_ENABLE, 2'h0};
   localparam logic [11:0] ADDR_ROUTING = {2'h0, IDX_ROUTING, 2'h0};
   localparam logic [11:0] ADDR_PADCFG  = {2'h0, IDX_PADCFG, 2'h0};
   localparam logic [11:0] ADDR_STATUS  = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [11:0] ADDR_MASK    = {2'h0, IDX_MASK, 2'h0};
   localparam logic [11:0] ADDR_SOURCE  = {2'h0, IDX_SOURCE, 2'h0};
   // Source bit positions
   localparam int BIT_SLEEP  = 7;
   localparam int BIT_FIFO   = 6;
   localparam int BIT_TRANS  = 5;
   localparam int BIT_ORIENT = 4;
   localparam int BIT_PULSE  = 3;
   localparam int BIT_FALL   = 2;
   localparam int BIT_READY  = 0;
   // Bit 1 is unimplemented in enable and routing
   localparam logic [7:0] SRC_IMPL_MASK = 8'hfd;
   localparam int BIT_LEVEL = 0;
   localparam int BIT_DRIVE = 1;
   localparam logic [7:0] RST_ENABLE  = 8'h00;
   localparam logic [7:0] RST_ROUTING = 8'h00;
   localparam logic [1:0] RST_PADCFG  = 2'h0;
   localparam logic [1:0] RST_STATUS  = 2'h0;
   localparam logic [1:0] RST_MASK    = 2'h0;
endpackage : ier_pkg

// *** hw/ier_route_bit.sv ***
// One source lane: enable gate and pin selection.
// Assumes the event level is synchronous to pclk.
module ier_route_bit (
   // Source
   input  wire logic event_in,
   input  wire logic enable,
   input  wire logic route,
   // Pin requests
   output logic      to_pin_a,
   output logic      to_pin_b
);
   logic gated;
   assign gated    = event_in & enable;
   assign to_pin_a = gated & route;
   assign to_pin_b = gated & ~route;
endmodule // ier_route_bit

// *** hw/ier_pad.sv ***
// Pad shaping of one interrupt pin: level and drive mode.
// Assumes the assert request is registered by the caller.
module ier_pad (
   // Request and config
   input  wire logic assert_req,
   input  wire logic active_high,
   input  wire logic open_drain,
   // Pad
   output logic      pin_out,
   output logic      pin_oe_n
);
   always_comb begin
      pin_out  = assert_req ? active_high : ~active_high;
      // Open drain only drives the asserted low level
      pin_oe_n = open_drain ? ~(assert_req && !active_high) : 1'b0;
   end
endmodule // ier_pad

// *** hw/ier_top.sv ***
// Interrupt enable and pin routing block with APB register access.
// Assumes event levels synchronous to pclk and a standard APB master.

// Summary of operation
// - Enable bit 7 gates the auto-sleep/wake event onto the pins.
// - Enable bit 6 gates the buffer event onto the pins.
// - Enable bit 5 gates the transient event onto the pins.
// - Enable bit 4 gates the orientation event onto the pins.
// - Enable bit 3 gates the pulse event onto the pins.
// - Enable bit 2 gates the fall/motion event onto the pins.
// - Enable bit 0 gates the sample-ready event onto the pins.
// - Enable register resets to zero; no pin asserts until enabled.
// - Event flags pass to routing only while their enable is set.
// - Routing bit one selects pin a, zero selects pin b.
// - Routing register resets to zero, defaulting all to pin b.
// - A pin asserts while any enabled source routed to it is active.
// - Level bit: zero asserts low, one asserts high, both pins.
// - Drive bit: zero push-pull, one open drain.
module ier_top
   import ier_pkg::*;
#(
   parameter int NSRC = 8
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Event levels from detectors
   input  wire logic [7:0]  event_lvl,
   // Interrupt pins
   output logic             irq_pin_a,
   output logic             irq_pin_a_oe_n,
   output logic             irq_pin_b,
   output logic             irq_pin_b_oe_n,
   // Summary interrupt to local processor
   output logic             irq
);

   typedef struct packed {
      logic [7:0]  en;
      logic [7:0]  route;
      logic [1:0]  padcfg;
      logic [1:0]  sts;
      logic [1:0]  mask;
      logic        req_a;
      logic        req_b;
      logic        pin_a;
      logic        oe_a;
      logic        pin_b;
      logic        oe_b;
      logic        irq;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
   } ier_state_t;

   ier_state_t st_ff;
   ier_state_t nxt_st;

   logic [7:0] lane_a;
   logic [7:0] lane_b;
   logic       any_a;
   logic       any_b;
   logic       pad_a;
   logic       pad_a_oe_n;
   logic       pad_b;
   logic       pad_b_oe_n;
   logic       acc;
   logic       wr;
   logic       rd;
   logic [7:0] src_seen;

   // One lane per source position; bit 1 has no source
   for (genvar i = 0; i < NSRC; i++) begin : g_lane
      ier_route_bit u_lane (
         .event_in (event_lvl[i]),
         .enable   (st_ff.en[i]),
         .route    (st_ff.route[i]),
         .to_pin_a (lane_a[i]),
         .to_pin_b (lane_b[i])
      );
   end

   assign any_a    = |lane_a;
   assign any_b    = |lane_b;
   assign src_seen = event_lvl & st_ff.en & SRC_IMPL_MASK;

   // Pad shaping sits before the output flops so pins stay registered
   ier_pad u_pad_a (
      .assert_req  (st_ff.req_a),
      .active_high (st_ff.padcfg[BIT_LEVEL]),
      .open_drain  (st_ff.padcfg[BIT_DRIVE]),
      .pin_out     (pad_a),
      .pin_oe_n    (pad_a_oe_n)
   );
   ier_pad u_pad_b (
      .assert_req  (st_ff.req_b),
      .active_high (st_ff.padcfg[BIT_LEVEL]),
      .open_drain  (st_ff.padcfg[BIT_DRIVE]),
      .pin_out     (pad_b),
      .pin_oe_n    (pad_b_oe_n)
   );

   // Zero wait states: answer in the access phase itself
   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.req_a = any_a;
      nxt_st.req_b = any_b;
      nxt_st.pin_a = pad_a;
      nxt_st.oe_a  = pad_a_oe_n;
      nxt_st.pin_b = pad_b;
      nxt_st.oe_b  = pad_b_oe_n;
      nxt_st.ready = psel & ~penable;
      nxt_st.err   = 1'b0;
      nxt_st.rdata = 32'h0000_0000;
      // Sticky pin events; set wins over read-clear below
      if (wr) begin
         case (paddr)
            ADDR_ENABLE:  nxt_st.en = pwdata[7:0] & SRC_IMPL_MASK;
            ADDR_ROUTING: nxt_st.route = pwdata[7:0] & SRC_IMPL_MASK;
            ADDR_PADCFG:  nxt_st.padcfg = pwdata[1:0];
            ADDR_MASK:    nxt_st.mask = pwdata[1:0];
            ADDR_STATUS:  ;
            ADDR_SOURCE:  ;
            default:      nxt_st.err = psel & ~penable;
         endcase
      end
      if (psel && !penable) begin
         case (paddr)
            ADDR_ENABLE:  nxt_st.rdata = {24'h0, st_ff.en};
            ADDR_ROUTING: nxt_st.rdata = {24'h0, st_ff.route};
            ADDR_PADCFG:  nxt_st.rdata = {30'h0, st_ff.padcfg};
            ADDR_STATUS:  nxt_st.rdata = {30'h0, st_ff.sts};
            ADDR_MASK:    nxt_st.rdata = {30'h0, st_ff.mask};
            ADDR_SOURCE:  nxt_st.rdata = {24'h0, src_seen};
            default:      nxt_st.err = 1'b1;
         endcase
      end
      if (rd && paddr == ADDR_STATUS) begin
         nxt_st.sts = 2'h0;
      end
      if (any_a) begin
         nxt_st.sts[0] = 1'b1;
      end
      if (any_b) begin
         nxt_st.sts[1] = 1'b1;
      end
      nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff        <= '0;
         st_ff.en     <= RST_ENABLE;
         st_ff.route  <= RST_ROUTING;
         st_ff.padcfg <= RST_PADCFG;
         st_ff.sts    <= RST_STATUS;
         st_ff.mask   <= RST_MASK;
         st_ff.pin_a  <= 1'b1;
         st_ff.pin_b  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Read data and ready leave the flops straight
   assign prdata         = st_ff.rdata;
   assign pready         = st_ff.ready;
   assign pslverr        = st_ff.err;
   assign irq_pin_a      = st_ff.pin_a;
   assign irq_pin_a_oe_n = st_ff.oe_a;
   assign irq_pin_b      = st_ff.pin_b;
   assign irq_pin_b_oe_n = st_ff.oe_b;
   assign irq            = st_ff.irq;

   // Assertions
   a_sleep_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !st_ff.en[BIT_SLEEP] |-> !lane_a[BIT_SLEEP] && !lane_b[BIT_SLEEP])
      else $error("sleep event passed while disabled");
   a_fifo_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (event_lvl[BIT_FIFO] && st_ff.en[BIT_FIFO]) |->
      (lane_a[BIT_FIFO] || lane_b[BIT_FIFO]))
      else $error("enabled fifo event lost");
   a_trans_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_a[BIT_TRANS] || lane_b[BIT_TRANS]) |-> st_ff.en[BIT_TRANS])
      else $error("transient passed while disabled");
   a_orient_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_a[BIT_ORIENT] | lane_b[BIT_ORIENT]) ==
      (event_lvl[BIT_ORIENT] & st_ff.en[BIT_ORIENT]))
      else $error("orientation gating wrong");
   a_pulse_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_a[BIT_PULSE] | lane_b[BIT_PULSE]) ==
      (event_lvl[BIT_PULSE] & st_ff.en[BIT_PULSE]))
      else $error("pulse gating wrong");
   a_fall_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_a[BIT_FALL] | lane_b[BIT_FALL]) ==
      (event_lvl[BIT_FALL] & st_ff.en[BIT_FALL]))
      else $error("fall gating wrong");
   a_ready_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_a[BIT_READY] | lane_b[BIT_READY]) ==
      (event_lvl[BIT_READY] & st_ff.en[BIT_READY]))
      else $error("ready gating wrong");
   a_route_sel: assert property (@(posedge pclk) disable iff (!presetn)
      (lane_a & ~st_ff.route) == 8'h00 && (lane_b & st_ff.route) == 8'h00)
      else $error("source on wrong pin");
   a_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 $past(st_ff.req_a) && $past(!st_ff.padcfg[BIT_DRIVE]) |->
      irq_pin_a == $past(st_ff.padcfg[BIT_LEVEL]) && !irq_pin_a_oe_n)
      else $error("pin a level wrong");
   a_pin_assert: assert property (@(posedge pclk) disable iff (!presetn)
      any_b |=> st_ff.req_b ##1 (irq_pin_b == st_ff.padcfg[BIT_LEVEL]
      || $changed(st_ff.padcfg)))
      else $error("pin b not asserted");
   a_od_release: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 $past(st_ff.padcfg[BIT_DRIVE]) && !$past(st_ff.req_a) |->
      irq_pin_a_oe_n)
      else $error("open drain drove idle");
   a_bit1_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !st_ff.en[1] && !st_ff.route[1])
      else $error("bit 1 stored");
   a_reset_clear: assert property (@(posedge pclk)
      $rose(presetn) |-> st_ff.en == 8'h00 && st_ff.route == 8'h00)
      else $error("registers not cleared");
   c_pin_a: cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.req_a);
   c_pin_b: cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.req_b);
   c_both: cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.req_a && st_ff.req_b && st_ff.padcfg == 2'h3);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn)
      irq);
   c_err: cover property (@(posedge pclk) disable iff (!presetn)
      pslverr);

   // Pass side of the gates, with a_fifo_block on the block side: an enabled event must reach its pin
   a_sleep_pass: assert property (@(posedge pclk) disable iff (!presetn)
      event_lvl[BIT_SLEEP] && st_ff.en[BIT_SLEEP] && st_ff.route[BIT_SLEEP]
      |-> lane_a[BIT_SLEEP])
      else $error("enabled sleep event lost");
   a_sleep_pin_b: assert property (@(posedge pclk) disable iff (!presetn)
      event_lvl[BIT_SLEEP] && st_ff.en[BIT_SLEEP] && !st_ff.route[BIT_SLEEP]
      |-> lane_b[BIT_SLEEP])
      else $error("sleep event not on pin b");
   a_fifo_block: assert property (@(posedge pclk) disable iff (!presetn)
      !st_ff.en[BIT_FIFO] |-> !(lane_a[BIT_FIFO] || lane_b[BIT_FIFO]))
      else $error("fifo passed while disabled");
   a_trans_pass: assert property (@(posedge pclk) disable iff (!presetn)
      event_lvl[BIT_TRANS] && st_ff.en[BIT_TRANS] |->
      lane_a[BIT_TRANS] || lane_b[BIT_TRANS])
      else $error("enabled transient lost");

   // Pin requests, sticky status, irq and source view
   a_req_a_follow: assert property (@(posedge pclk) disable iff (!presetn)
      any_a |=> st_ff.req_a)
      else $error("pin a request missing");
   a_req_b_follow: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> st_ff.req_b == $past(any_b))
      else $error("pin b request wrong");
   a_sts_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      any_a |=> st_ff.sts[0])
      else $error("pin a status not set");
   a_sts_set_b: assert property (@(posedge pclk) disable iff (!presetn)
      any_b |=> st_ff.sts[1])
      else $error("pin b status not set");
   a_sts_clear: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == ADDR_STATUS && !any_a && !any_b |=> st_ff.sts == 2'h0)
      else $error("status not cleared by read");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(st_ff.sts & st_ff.mask))
      else $error("irq does not follow status");
   a_src_view: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && paddr == ADDR_SOURCE |=>
      prdata == {24'h0, $past(src_seen)})
      else $error("source view wrong");

   // Pad shaping
   a_pp_drive: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 !$past(st_ff.padcfg[BIT_DRIVE]) |-> !irq_pin_b_oe_n)
      else $error("push-pull released pin");
   a_pin_b_idle: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 !$past(st_ff.req_b) && !$past(st_ff.padcfg[BIT_DRIVE]) |->
      irq_pin_b == !$past(st_ff.padcfg[BIT_LEVEL]))
      else $error("pin b idle level wrong");

   // Register bus
   a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held too long");
   a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");
   a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == ADDR_ENABLE |=>
      st_ff.en == ($past(pwdata[7:0]) & SRC_IMPL_MASK))
      else $error("enable write lost");
   a_route_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == ADDR_ROUTING |=>
      st_ff.route == ($past(pwdata[7:0]) & SRC_IMPL_MASK))
      else $error("routing write lost");

endmodule // ier_top

// *** test/ier_host_model.sv ***
// Host model: senses both interrupt lines as board wiring resolves them.
// Assumes the bench tells it which line level means asserted.
module ier_host_model (
   // Pads
   input  wire logic pin_a,
   input  wire logic oe_n_a,
   input  wire logic pin_b,
   input  wire logic oe_n_b,
   // Sense level and result
   input  wire logic level,
   output logic      seen_a,
   output logic      seen_b
);
   timeunit 1ns;
   timeprecision 1ns;
   logic line_a;
   logic line_b;
   // A released line floats up to the board pull-up
   assign line_a = oe_n_a ? 1'b1 : pin_a;
   assign line_b = oe_n_b ? 1'b1 : pin_b;
   // A line alone does not name the source, so the bench reads it
   assign seen_a = (line_a === level);
   assign seen_b = (line_b === level);
endmodule // ier_host_model

// *** test/interrupt_enable_routing_tb_top.sv ***
// Bench for the interrupt enable and pin routing block.
// Assumes ier_pkg, the design and the host model are compiled first.
module interrupt_enable_routing_tb_top;
   import ier_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  ev, en, rt;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        irq, pa, pa_oe_n, pb, pb_oe_n, lvl, od, sa, sb;
   logic [32:0] q[$];
   int          errors, compares;
   int          src[7] = '{7, 6, 5, 4, 3, 2, 0};

   ier_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_lvl(ev),
      .irq_pin_a(pa), .irq_pin_a_oe_n(pa_oe_n), .irq_pin_b(pb),
      .irq_pin_b_oe_n(pb_oe_n), .irq(irq));
   ier_host_model i_host (.pin_a(pa), .oe_n_a(pa_oe_n), .pin_b(pb),
      .oe_n_b(pb_oe_n), .level(lvl), .seen_a(sa), .seen_b(sb));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic fail(input string m);
      errors++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("bus got %h exp %h", got, exp));
   endtask
   task automatic cmp_pin(input logic [2:0] got, input logic [2:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("pins got %b exp %b", got, exp));
   endtask
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Called just after a rising edge; holds the request until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e = '0);
      int n = 0;
      if (!w) q.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) fail("no answer on the bus");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Pin path lags two cycles; the third edge samples settled values
   // Active-high open drain never drives, so the pull-up reads asserted
   task automatic chk(input logic ea, input logic eb);
      repeat (3) @(posedge pclk);
      cmp_pin({sa, sb, pa_oe_n}, {ea | (od & lvl), eb | (od & lvl),
              od & ~(ea & ~lvl)});
   endtask
   task automatic irq_is(input logic e);
      repeat (4) @(posedge pclk);
      cmp_pin({2'b0, irq}, {2'b0, e});
   endtask

   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         cmp_bus({pslverr, prdata}, q.pop_front());

   initial begin
      #100us;
      fail("watchdog expired");
      tally_and_finish;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, ev, lvl, od} = '0;
      presetn = 1'b0;
      errors = 0;
      compares = 0;
      void'($urandom(32'hadd6));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      ev <= 8'hfd;
      apb(0, ADDR_ENABLE, 0, 33'h0);
      apb(0, ADDR_ROUTING, 0, 33'h0);
      chk(0, 0);
      apb(1, ADDR_ENABLE, 32'hff);
      apb(0, ADDR_ENABLE, 0, 33'hfd);
      chk(0, 1);
      apb(1, ADDR_ROUTING, 32'hff);
      apb(0, ADDR_ROUTING, 0, 33'hfd);
      chk(1, 0);
      for (int i = 0; i < 7; i++) begin
         en = 8'h1 << src[i];
         rt = 8'($urandom) & 8'hfd;
         ev <= 8'($urandom) | en;
         apb(1, ADDR_ENABLE, {24'h0, en});
         apb(1, ADDR_ROUTING, {24'h0, rt});
         chk(|(rt & en), ~|(rt & en));
         ev <= ev & ~en;
         chk(0, 0);
      end
      en = 8'hfd;
      rt = (8'($urandom) & 8'h7c) | 8'h80;
      ev <= 8'($urandom) | 8'h81;
      apb(1, ADDR_ENABLE, {24'h0, en});
      apb(1, ADDR_ROUTING, {24'h0, rt});
      chk(|(ev & en & rt), |(ev & en & ~rt));
      apb(0, ADDR_SOURCE, 0, {25'h0, ev & en});
      for (int m = 0; m < 4; m++) begin
         {od, lvl} = 2'(m);
         ev <= 8'h81;
         apb(1, ADDR_PADCFG, m);
         apb(0, ADDR_PADCFG, 0, 33'(m));
         chk(1, 1);
         ev <= 8'h00;
         chk(0, 0);
      end
      {od, lvl} = 2'h0;
      apb(1, ADDR_PADCFG, 0);
      apb(0, ADDR_STATUS, 0, 33'h3);
      apb(0, ADDR_STATUS, 0, 33'h0);
      irq_is(0);
      apb(1, ADDR_MASK, 32'h1);
      ev <= 8'h01;
      irq_is(0);
      ev <= 8'h80;
      irq_is(1);
      ev <= 8'h00;
      apb(0, ADDR_STATUS, 0, 33'h3);
      irq_is(0);
      apb(0, 12'hffc, 0, {1'b1, 32'h0});
      tally_and_finish;
   end
endmodule // interrupt_enable_routing_tb_top
